// ---- pkg/tic_pkg.sv ----
`default_nettype none
package tic_pkg;

  // ----------------------------------------------------------------
  // widths and counter constants
  // ----------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam int CTRL_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ALL_ONES = 16'hFFFF;

  // ----------------------------------------------------------------
  // timer control byte layout
  // ----------------------------------------------------------------
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_EDGE_BIT = 1;
  localparam int CTRL_IRQEN_BIT = 2;
  localparam int CTRL_PEND_BIT = 3;
  localparam int CTRL_PAIR_LO = 4;
  localparam int CTRL_PAIR_HI = 5;
  localparam int CTRL_MODE_LO = 6;
  localparam int CTRL_MODE_HI = 7;
  localparam logic [CTRL_W-1:0] CTRL_BYTE_RESET = 8'h00;

  // mode field codes in the control byte
  localparam logic [1:0] MODE_CODE_PWM = 2'h0;
  localparam logic [1:0] MODE_CODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_CODE_CAPTURE = 2'h2;
  localparam logic [1:0] MODE_CODE_DIFF = 2'h3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TIC_MODE_PWM = 4'h1,
    TIC_MODE_EVENT = 4'h2,
    TIC_MODE_CAPTURE = 4'h4,
    TIC_MODE_DIFF = 4'h8
  } tic_mode_e;

  typedef enum logic [2:0] {
    DIFF_IDLE = 3'h1,
    DIFF_WAIT = 3'h2,
    DIFF_COUNT = 3'h4
  } tic_diff_e;

  typedef struct packed {
    tic_mode_e mode;
    logic [1:0] pairing;
    logic edgeSel;
    logic irqEn;
    logic pend;
    logic run;
  } tic_ctrl_s;

  localparam tic_ctrl_s CTRL_RESET = '{
    mode: TIC_MODE_PWM,
    pairing: 2'h0,
    edgeSel: 1'b0,
    irqEn: 1'b0,
    pend: 1'b0,
    run: 1'b0
  };

  // ----------------------------------------------------------------
  // control byte <-> struct
  // ----------------------------------------------------------------
  function automatic tic_ctrl_s tic_decode(input logic [CTRL_W-1:0] b);
    tic_ctrl_s c;
    c = CTRL_RESET;
    case (b[CTRL_MODE_HI:CTRL_MODE_LO])
      MODE_CODE_EVENT: c.mode = TIC_MODE_EVENT;
      MODE_CODE_CAPTURE: c.mode = TIC_MODE_CAPTURE;
      MODE_CODE_DIFF: c.mode = TIC_MODE_DIFF;
      default: c.mode = TIC_MODE_PWM;
    endcase
    c.pairing = b[CTRL_PAIR_HI:CTRL_PAIR_LO];
    c.edgeSel = b[CTRL_EDGE_BIT];
    c.irqEn = b[CTRL_IRQEN_BIT];
    c.pend = b[CTRL_PEND_BIT];
    c.run = b[CTRL_RUN_BIT];
    return c;
  endfunction

  function automatic logic [CTRL_W-1:0] tic_encode(input tic_ctrl_s c);
    logic [CTRL_W-1:0] b;
    b = CTRL_BYTE_RESET;
    case (c.mode)
      TIC_MODE_EVENT: b[CTRL_MODE_HI:CTRL_MODE_LO] = MODE_CODE_EVENT;
      TIC_MODE_CAPTURE: b[CTRL_MODE_HI:CTRL_MODE_LO] = MODE_CODE_CAPTURE;
      TIC_MODE_DIFF: b[CTRL_MODE_HI:CTRL_MODE_LO] = MODE_CODE_DIFF;
      default: b[CTRL_MODE_HI:CTRL_MODE_LO] = MODE_CODE_PWM;
    endcase
    b[CTRL_PAIR_HI:CTRL_PAIR_LO] = c.pairing;
    b[CTRL_EDGE_BIT] = c.edgeSel;
    b[CTRL_IRQEN_BIT] = c.irqEn;
    b[CTRL_PEND_BIT] = c.pend;
    b[CTRL_RUN_BIT] = c.run;
    return b;
  endfunction

endpackage
`default_nettype wire

// ---- hdl/tic_timer_capture.sv ----
`timescale 1ns/1ps
`default_nettype none
module tic_timer_capture
  import tic_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // timer pin
  input wire logic timerPin,
  // software writes
  input wire logic ctrlWr,
  input wire logic [CTRL_W-1:0] ctrlWrData,
  input wire logic countWr,
  input wire logic [CNT_W-1:0] countWrData,
  input wire logic reloadWr,
  input wire logic [CNT_W-1:0] reloadWrData,
  // processor global interrupt enable
  input wire logic globalIrqEnable,
  // state seen by software
  output logic [CTRL_W-1:0] timerControlReg,
  output tic_ctrl_s ctrlState,
  output logic [CNT_W-1:0] countRegister,
  output logic [CNT_W-1:0] captureReloadA,
  // interrupt to the core
  output logic timerInterrupt
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rstPipe;
  logic rstn;

  // asserts at once, lifts on the clock so no flop sees a ragged release
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  assign rstn = rstPipe[1];

  // ----------------------------------------------------------------
  // pin synchroniser and edge detect
  // ----------------------------------------------------------------
  logic pinMeta;
  logic pinSync;
  logic pinPrev;
  logic pinRise;
  logic pinFall;

  // pinMeta feeds only pinSync; edges compare the two settled samples
  // zero after reset suits a low idle pin; a high idle pin gives one false rise
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pinMeta <= 1'b0;
      pinSync <= 1'b0;
      pinPrev <= 1'b0;
    end else begin
      pinMeta <= timerPin;
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end

  assign pinRise = pinSync & ~pinPrev;
  assign pinFall = ~pinSync & pinPrev;

  // ----------------------------------------------------------------
  // edge selection
  // ----------------------------------------------------------------
  tic_ctrl_s ctrl;
  tic_diff_e diffState;
  logic inCapture;
  logic inDiff;
  logic capModes;
  logic selEdge;
  logic firstEdge;
  logic secondEdge;

  assign inCapture = ctrl.mode == TIC_MODE_CAPTURE;
  assign inDiff = ctrl.mode == TIC_MODE_DIFF;
  assign capModes = inCapture || inDiff;
  // read live each cycle, so a change takes effect on the next edge only
  assign selEdge = ctrl.edgeSel ? pinRise : pinFall;
  // pairing: bit 1 first edge falling, second falling when both bits agree
  assign firstEdge = ctrl.pairing[1] ? pinFall : pinRise;
  assign secondEdge = (ctrl.pairing[1] == ctrl.pairing[0]) ? pinFall : pinRise;

  // ----------------------------------------------------------------
  // software write decode
  // ----------------------------------------------------------------
  tic_ctrl_s wrCtrl;
  logic modeChange;
  logic pairChange;
  logic diffRestart;

  assign wrCtrl = tic_decode(ctrlWrData);
  assign modeChange = wrCtrl.mode != ctrl.mode;
  assign pairChange = wrCtrl.pairing != ctrl.pairing;
  // flag-only writes leave a running measurement alone
  assign diffRestart = ctrlWr && (modeChange || pairChange);

  // ----------------------------------------------------------------
  // count wrap points
  // ----------------------------------------------------------------
  logic atZero;
  logic atTop;

  assign atZero = countRegister == CNT_ZERO;
  assign atTop = countRegister == CNT_ALL_ONES;

  // ----------------------------------------------------------------
  // counter, capture and mode sequencing
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] next_captureA;
  tic_diff_e next_diffState;
  logic underflowEvt;
  logic captureEvt;

  always_comb begin
    next_count = countRegister;
    next_captureA = captureReloadA;
    next_diffState = diffState;
    underflowEvt = 1'b0;
    captureEvt = 1'b0;
    case (ctrl.mode)
      TIC_MODE_PWM: begin
        if (ctrl.run) begin
          if (atZero) begin
            next_count = captureReloadA;
            underflowEvt = 1'b1;
          end else begin
            next_count = countRegister - CNT_ONE;
          end
        end
      end
      TIC_MODE_EVENT: begin
        // event mode steps on selected pin edges, not on the clock
        if (ctrl.run && selEdge) begin
          if (atZero) begin
            next_count = captureReloadA;
            underflowEvt = 1'b1;
          end else begin
            next_count = countRegister - CNT_ONE;
          end
        end
      end
      TIC_MODE_CAPTURE: begin
        // free running, the run bit is no start/stop here
        next_count = countRegister - CNT_ONE;
        underflowEvt = atZero;
        if (selEdge) begin
          captureEvt = 1'b1;
          next_captureA = countRegister;
        end
      end
      TIC_MODE_DIFF: begin
        case (diffState)
          DIFF_WAIT: begin
            if (firstEdge) begin
              next_count = CNT_ZERO;
              next_diffState = DIFF_COUNT;
            end
          end
          DIFF_COUNT: begin
            if (secondEdge) begin
              // count stops; stored value covers the edge cycle too
              captureEvt = 1'b1;
              next_captureA = countRegister + CNT_ONE;
              next_diffState = DIFF_WAIT;
            end else begin
              next_count = countRegister + CNT_ONE;
              underflowEvt = atTop;
            end
          end
          default: begin
            next_diffState = DIFF_WAIT;
          end
        endcase
      end
      default: begin
        next_count = countRegister;
      end
    endcase
    // a software load wins over the running count
    if (countWr) begin
      next_count = countWrData;
    end
    // hardware capture wins over a software reload write
    if (reloadWr && !captureEvt) begin
      next_captureA = reloadWrData;
    end
    // new mode or new pairing restarts the difference measurement
    if (diffRestart) begin
      next_diffState = (wrCtrl.mode == TIC_MODE_DIFF) ? DIFF_WAIT : DIFF_IDLE;
    end
  end

  // all ones at reset, the usual load ahead of capture
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      countRegister <= CNT_ALL_ONES;
    end else begin
      countRegister <= next_count;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      captureReloadA <= CNT_ZERO;
    end else begin
      captureReloadA <= next_captureA;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      diffState <= DIFF_IDLE;
    end else begin
      diffState <= next_diffState;
    end
  end

  // ----------------------------------------------------------------
  // control register and pending flags
  // ----------------------------------------------------------------
  logic pendSet;
  logic runSet;
  tic_ctrl_s next_ctrl;

  // outside capture modes an underflow is the only pending source
  assign pendSet = captureEvt | (underflowEvt & ~capModes);
  assign runSet = underflowEvt & capModes;

  always_comb begin
    next_ctrl = ctrlWr ? wrCtrl : ctrl;
    // hardware set wins over a same-cycle software clear
    next_ctrl.pend = next_ctrl.pend | pendSet;
    next_ctrl.run = next_ctrl.run | runSet;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl <= CTRL_RESET;
      ctrlState <= CTRL_RESET;
      timerControlReg <= CTRL_BYTE_RESET;
    end else begin
      ctrl <= next_ctrl;
      ctrlState <= next_ctrl;
      timerControlReg <= tic_encode(next_ctrl);
    end
  end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  logic capRise;
  logic runRise;
  logic next_irq;

  // a flag already set gives no new request
  assign capRise = pendSet & ~ctrl.pend;
  assign runRise = runSet & ~ctrl.run;
  // gated by the enable as written this cycle
  assign next_irq = next_ctrl.irqEn & globalIrqEnable & (capRise | runRise);

  // one-cycle pulse; the flags keep the cause for software
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      timerInterrupt <= 1'b0;
    end else begin
      timerInterrupt <= next_irq;
    end
  end

endmodule
`default_nettype wire

// ---- test/tic_pin_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module tic_pin_source (
  // clock
  input wire logic clk_sys,
  // driven pin
  output logic timerPin
);
  initial timerPin = 1'b0;
  // level changes off the sampling edge, held whole cycles only
  task automatic drive(input logic lvl, input int n);
    @(negedge clk_sys);
    timerPin = lvl;
    repeat ((n < 1) ? 0 : n - 1) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ---- test/tic_timer_capture_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module tic_timer_capture_asserts
  import tic_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // inputs watched
  input wire logic ctrlWr,
  input wire logic countWr,
  input wire logic globalIrqEnable,
  // outputs watched
  input wire logic [CTRL_W-1:0] timerControlReg,
  input wire tic_ctrl_s ctrlState,
  input wire logic [CNT_W-1:0] countRegister,
  input wire logic [CNT_W-1:0] captureReloadA,
  input wire logic timerInterrupt
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic capNow;
  logic diffNow;
  assign capNow = ctrlState.mode == TIC_MODE_CAPTURE;
  assign diffNow = ctrlState.mode == TIC_MODE_DIFF;
  AST_CAP_COPY: assert property (
    $rose(ctrlState.pend) && $past(capNow) && !$past(ctrlWr) |-> captureReloadA == $past(countRegister))
    else $error("captured value differs from count");
  AST_DOWN_COUNT: assert property (
    capNow && $past(capNow) && !$past(countWr) |-> countRegister == $past(countRegister) - CNT_ONE)
    else $error("capture count did not step down");
  AST_UNDERFLOW: assert property (
    capNow && $past(capNow) && !$past(countWr) && $past(countRegister) == CNT_ZERO
    |-> ctrlState.run && countRegister == CNT_ALL_ONES)
    else $error("underflow flag not set");
  AST_DIFF_UP: assert property (
    diffNow && $past(diffNow) && !$past(countWr) && countRegister != CNT_ZERO
    && countRegister != $past(countRegister) |-> countRegister == $past(countRegister) + CNT_ONE)
    else $error("difference count did not step up");
  AST_IRQ_GATE: assert property (
    timerInterrupt |-> ctrlState.irqEn && $past(globalIrqEnable))
    else $error("interrupt while masked");
  AST_IRQ_CAUSE: assert property (
    timerInterrupt |-> $rose(ctrlState.pend) || $rose(ctrlState.run))
    else $error("interrupt without new flag");
  AST_IRQ_ON_FLAG: assert property (
    $rose(ctrlState.pend) && !$past(ctrlWr) && ctrlState.irqEn && $past(globalIrqEnable) |-> timerInterrupt)
    else $error("flag set without interrupt");
  AST_PEND_HOLD: assert property (
    $past(ctrlState.pend) && !$past(ctrlWr) |-> ctrlState.pend)
    else $error("capture flag dropped");
  AST_BOTH_FLAGS: assert property (
    $rose(ctrlState.pend) && $past(capNow) && !$past(ctrlWr) && $past(countRegister) == CNT_ZERO
    |-> ctrlState.run)
    else $error("capture at underflow lost a flag");
  AST_RUN_HOLD: assert property (
    $past(ctrlState.run) && !$past(ctrlWr) |-> ctrlState.run)
    else $error("underflow flag dropped");
  AST_PEND_BIT: assert property (
    timerControlReg[CTRL_PEND_BIT] == ctrlState.pend)
    else $error("flag bit position wrong");
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import tic_pkg::*;
;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic ctrlWr = 1'b0;
  logic countWr = 1'b0;
  logic reloadWr = 1'b0;
  logic globalIrqEnable = 1'b1;
  logic [7:0] ctrlWrData = 8'h00;
  logic [15:0] countWrData = 16'h0000;
  logic [15:0] reloadWrData = 16'h0000;
  wire logic timerPin;
  logic [7:0] timerControlReg;
  tic_ctrl_s ctrlState;
  logic [15:0] countRegister;
  logic [15:0] captureReloadA;
  logic timerInterrupt;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int irqCnt = 0;
  int c0;
  logic [31:0] seed = 32'hB7B0069B;
  logic st;
  logic [15:0] w1, w2, a, x;

  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    irqCnt += (timerInterrupt === 1'b1) ? 1 : 0;
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      close_out();
    end
  end

  tic_pin_source i_tic_pin_source (.clk_sys(clk_sys), .timerPin(timerPin));
  tic_timer_capture i_tic_timer_capture (.clk_sys(clk_sys), .nrst(nrst), .timerPin(timerPin),
    .ctrlWr(ctrlWr), .ctrlWrData(ctrlWrData), .countWr(countWr), .countWrData(countWrData),
    .reloadWr(reloadWr), .reloadWrData(reloadWrData), .globalIrqEnable(globalIrqEnable),
    .timerControlReg(timerControlReg), .ctrlState(ctrlState), .countRegister(countRegister),
    .captureReloadA(captureReloadA), .timerInterrupt(timerInterrupt));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // same-direction pairings span two level periods
  function automatic logic [15:0] exp_diff(input logic [1:0] p, input logic [15:0] u, input logic [15:0] v);
    return p[0] ? u + v : u;
  endfunction
  task automatic next_w(output logic [15:0] w, input logic [15:0] lo);
    seed = xs(seed);
    w = lo + {11'h000, seed[4:0]};
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] k, input logic [15:0] d);
    @(negedge clk_sys);
    ctrlWr = (k == 2'h0);
    countWr = (k == 2'h1);
    reloadWr = (k == 2'h2);
    ctrlWrData = d[7:0];
    countWrData = d;
    reloadWrData = d;
    @(negedge clk_sys);
    ctrlWr = 1'b0;
    countWr = 1'b0;
    reloadWr = 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clk_sys);
    chk("reset ctrl", {8'h00, timerControlReg}, 16'h0000);
    chk("reset count", countRegister, 16'hFFFF);
    chk("reset capture", captureReloadA, 16'h0000);
    $display("test reset done");
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    wr(2'h1, 16'hFFFF);
    wr(2'h0, 16'h0086);
    repeat (4) @(negedge clk_sys);
    chk("capture start", countRegister, 16'hFFFB);
    next_w(w1, 16'h000A);
    c0 = irqCnt;
    fork
      i_tic_pin_source.drive(1'b1, w1);
      begin
        repeat (6) @(negedge clk_sys);
        a = captureReloadA;
        chk("pend rise", {15'h0000, ctrlState.pend}, 16'h0001);
        chk("irq rise", 16'(irqCnt - c0), 16'h0001);
        wr(2'h0, 16'h0084);
        globalIrqEnable = 1'b0;
      end
    join
    c0 = irqCnt;
    i_tic_pin_source.drive(1'b0, 7);
    chk("pulse width", a - captureReloadA, w1);
    chk("irq masked", 16'(irqCnt - c0), 16'h0000);
    globalIrqEnable = 1'b1;
    wr(2'h1, 16'h0005);
    repeat (10) @(negedge clk_sys);
    chk("underflow flag", {15'h0000, ctrlState.run}, 16'h0001);
    wr(2'h0, 16'h0084);
    chk("flags cleared", {8'h00, timerControlReg}, 16'h0084);
    wr(2'h0, 16'h0086);
    wr(2'h1, 16'h0003);
    i_tic_pin_source.drive(1'b1, 4);
    chk("both flags", {14'h0000, ctrlState.run, ctrlState.pend}, 16'h0003);
    chk("capture at zero", captureReloadA, 16'h0000);
    $display("test capture done");
    wr(2'h0, 16'h0000);
    x = countRegister;
    repeat (5) @(negedge clk_sys);
    chk("stopped", countRegister, x);
    wr(2'h2, 16'h1234);
    chk("reload", captureReloadA, 16'h1234);
    wr(2'h0, 16'h0001);
    repeat (3) @(negedge clk_sys);
    chk("pwm run", countRegister, x - 16'h0003);
    wr(2'h0, 16'h0041);
    x = countRegister;
    i_tic_pin_source.drive(1'b0, 2);
    i_tic_pin_source.drive(1'b1, 2);
    i_tic_pin_source.drive(1'b0, 4);
    chk("event count", countRegister, x - 16'h0002);
    $display("test stop and run done");
    for (int p = 0; p < 4; p++) begin
      st = p[1];
      wr(2'h0, 16'h0000);
      i_tic_pin_source.drive(st, 4);
      wr(2'h0, {8'h00, 2'h3, p[1:0], 4'h0});
      next_w(w1, 16'h0002);
      next_w(w2, 16'h0002);
      i_tic_pin_source.drive(st, 3);
      i_tic_pin_source.drive(~st, w1);
      if (p[0]) begin
        i_tic_pin_source.drive(st, w2);
        i_tic_pin_source.drive(~st, 6);
      end else begin
        i_tic_pin_source.drive(st, 6);
      end
      chk("diff value", captureReloadA, exp_diff(p[1:0], w1, w2));
      chk("diff pend", {15'h0000, ctrlState.pend}, 16'h0001);
      $display("test diff pairing %0d done", p);
    end
    nrst = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("mid reset ctrl", {8'h00, timerControlReg}, 16'h0000);
    chk("mid reset capture", captureReloadA, 16'h0000);
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    $display("test mid-run reset done");
    close_out();
  end
endmodule

bind tic_timer_capture tic_timer_capture_asserts i_tic_timer_capture_asserts (.clk_sys(clk_sys), .nrst(nrst),
  .ctrlWr(ctrlWr), .countWr(countWr), .globalIrqEnable(globalIrqEnable), .timerControlReg(timerControlReg),
  .ctrlState(ctrlState), .countRegister(countRegister), .captureReloadA(captureReloadA),
  .timerInterrupt(timerInterrupt));
`default_nettype wire
